// [design/enhanced_timing_peripheral_ctrl.sv]
// The Avalon-MM register port and the address map were decided locally.
`timescale 1ns/1ns
module enhanced_timing_peripheral_ctrl (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Avalon-MM register slave.
	input wire logic [4:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Timer bases and neighbouring blocks.
	input wire logic [15:0] first_timer_count_i,
	input wire logic first_timer_tick_i,
	input wire logic [9:0] second_timer_count_i,
	input wire logic adc_enabled_i,
	output logic timer_reset_o,
	output logic adc_start_o,
	output logic peripheral_irq_flag_o,
	// Capture pin and its port latch.
	input wire logic capture_pin_i,
	input wire logic pin_direction_bit_i,
	input wire logic port_write_i,
	input wire logic port_data_i,
	// Driven pins.
	output logic primary_output_o,
	output logic primary_oe_n_o,
	output logic secondary_output_o,
	output logic secondary_oe_n_o
);
	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	// All registers of the block live in one packed struct.
	typedef struct packed {
		logic wait_n; // Low for the one cycle that answers a request.
		logic [31:0] rdata; // Read data, valid while wait is low.
		logic [7:0] ctrl; // Control register.
		logic [15:0] ccpr; // Capture/compare pair.
		logic flag; // Peripheral interrupt flag.
		logic sync1; // First synchroniser stage.
		logic sync2; // Second synchroniser stage.
		logic sync3; // Delayed copy for edge detection.
		logic port_q; // Port data latch as seen by capture.
		logic [3:0] presc; // Capture prescaler counter.
		logic match; // Match seen in the previous cycle.
		logic cmp_latch; // Compare output latch.
		logic pend_reset; // Special event waits for a timer tick.
		logic tmr_rst; // Timer reset pulse.
		logic adc_go; // Conversion start pulse.
		logic pwm; // Raw PWM level of the previous cycle.
		logic [7:0] dead; // Dead band countdown.
		logic p_out; // Primary pin level.
		logic p_oe_n; // Primary pin enable, low drives.
		logic s_out; // Secondary pin level.
		logic s_oe_n; // Secondary pin enable, low drives.
	} enhanced_timing_peripheral_state_t;

	enhanced_timing_peripheral_state_t st_q;
	enhanced_timing_peripheral_state_t st_d;

	// ---------------------------------------------------------------
	// Decode
	// ---------------------------------------------------------------
	logic [3:0] mode; // Mode select field.
	logic [1:0] upper; // Upper two mode bits, the mode family.
	logic is_capture, is_compare, is_pwm, access; // Family and bus answer decode.
	logic wr_ctrl, wr_low, wr_high, wr_stat; // Register write strobes.
	logic cap_src, rise, fall, cap_evt; // Capture source and its edges.
	logic match_now, match_evt, pwm_now, a_act, b_act; // Compare and PWM levels.

	// Mode and bus decode; a write lands only in its answer cycle.
	always_comb begin
		mode = st_q.ctrl[enhanced_timing_peripheral_pkg::CTRL_MODE_HI -: 4];
		upper = mode[3:2];
		is_capture = (upper == enhanced_timing_peripheral_pkg::UPPER_CAPTURE);
		is_compare = (mode == enhanced_timing_peripheral_pkg::MODE_CMP_TOGGLE) || (upper == 2'h2);
		is_pwm = (upper == enhanced_timing_peripheral_pkg::UPPER_PWM);
		access = (avs_read_i || avs_write_i) && !st_q.wait_n;
		wr_ctrl = access && avs_write_i && avs_byteenable_i[0]
			&& (avs_address_i == enhanced_timing_peripheral_pkg::OFS_CONTROL);
		wr_low = access && avs_write_i && avs_byteenable_i[0]
			&& (avs_address_i == enhanced_timing_peripheral_pkg::OFS_CAP_LOW);
		wr_high = access && avs_write_i && avs_byteenable_i[0]
			&& (avs_address_i == enhanced_timing_peripheral_pkg::OFS_CAP_HIGH);
		wr_stat = access && avs_write_i && avs_byteenable_i[0]
			&& (avs_address_i == enhanced_timing_peripheral_pkg::OFS_STATUS);
		// An output pin captures from its own port latch.
		cap_src = pin_direction_bit_i ? st_q.sync2 : st_q.port_q;
		// Edges are taken on the chosen source, so a port write is seen as well.
		rise = cap_src && !st_q.sync3;
		fall = !cap_src && st_q.sync3;
		// Event selection per capture mode.
		case (mode)
			enhanced_timing_peripheral_pkg::MODE_CAP_FALL: cap_evt = fall;
			enhanced_timing_peripheral_pkg::MODE_CAP_RISE: cap_evt = rise;
			enhanced_timing_peripheral_pkg::MODE_CAP_RISE4: cap_evt = rise && (st_q.presc == enhanced_timing_peripheral_pkg::PRESC_LAST_4);
			enhanced_timing_peripheral_pkg::MODE_CAP_RISE16: cap_evt = rise && (st_q.presc == enhanced_timing_peripheral_pkg::PRESC_LAST_16);
			default: cap_evt = 1'b0;
		endcase
		// Compare uses the first timer; a match acts once on its rise.
		match_now = is_compare && (first_timer_count_i == st_q.ccpr);
		match_evt = match_now && !st_q.match;
		// PWM runs on the second timer against a ten-bit duty.
		pwm_now = is_pwm && (second_timer_count_i
			< {st_q.ccpr[7:0], st_q.ctrl[enhanced_timing_peripheral_pkg::CTRL_DUTY_HI:enhanced_timing_peripheral_pkg::CTRL_DUTY_LO]});
		a_act = st_q.pwm && (st_q.dead == 8'h00);
		b_act = !st_q.pwm && (st_q.dead == 8'h00);
	end

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	// One process computes every next value of the block.
	always_comb begin
		st_d = st_q;
		// Bus answer: one cycle of low wait after each request.
		st_d.wait_n = !((avs_read_i || avs_write_i) && st_q.wait_n);
		st_d.rdata = 32'h0000_0000;
		if ((avs_read_i || avs_write_i) && st_q.wait_n && avs_read_i) begin
			case (avs_address_i)
				enhanced_timing_peripheral_pkg::OFS_CONTROL: st_d.rdata = {24'h00_0000, st_q.ctrl};
				enhanced_timing_peripheral_pkg::OFS_CAP_LOW: st_d.rdata = {24'h00_0000, st_q.ccpr[7:0]};
				enhanced_timing_peripheral_pkg::OFS_CAP_HIGH: st_d.rdata = {24'h00_0000, st_q.ccpr[15:8]};
				enhanced_timing_peripheral_pkg::OFS_STATUS: st_d.rdata = {31'h0000_0000, st_q.flag};
				default: st_d.rdata = 32'h0000_0000;
			endcase
		end
		// Bit 6 is never stored, so it always reads back as zero.
		if (wr_ctrl) begin
			st_d.ctrl = avs_writedata_i[7:0] & enhanced_timing_peripheral_pkg::CONTROL_WMASK;
		end
		if (wr_low) begin
			st_d.ccpr[7:0] = avs_writedata_i[7:0];
		end
		if (wr_high) begin
			st_d.ccpr[15:8] = avs_writedata_i[7:0];
		end
		// Pin synchroniser; the first stage feeds only the second.
		st_d.sync1 = capture_pin_i;
		st_d.sync2 = st_q.sync1;
		st_d.sync3 = cap_src;
		if (port_write_i) begin
			st_d.port_q = port_data_i;
		end
		// Prescaler counts rises; switching prescale keeps the count.
		if (!is_capture) begin
			st_d.presc = 4'h0;
		end else if (rise && cap_evt) begin
			st_d.presc = 4'h0;
		end else if (rise) begin
			st_d.presc = st_q.presc + 4'h1;
		end
		// Capture copies the whole first timer, overwriting any old pair.
		if (cap_evt) begin
			st_d.ccpr = first_timer_count_i;
		end
		// Flag: software write sets bit 0 value, hardware set wins.
		if (wr_stat) begin
			st_d.flag = avs_writedata_i[0];
		end
		if (cap_evt || match_evt) begin
			st_d.flag = 1'b1;
		end
		// Compare actions on the output latch.
		st_d.match = match_now;
		if (match_evt) begin
			case (mode)
				enhanced_timing_peripheral_pkg::MODE_CMP_TOGGLE: st_d.cmp_latch = !st_q.cmp_latch;
				enhanced_timing_peripheral_pkg::MODE_CMP_SET: st_d.cmp_latch = 1'b1;
				enhanced_timing_peripheral_pkg::MODE_CMP_CLEAR: st_d.cmp_latch = 1'b0;
				default: st_d.cmp_latch = st_q.cmp_latch;
			endcase
		end
		// Special event: trigger now, timer reset at next tick if still matching.
		st_d.adc_go = match_evt && (mode == enhanced_timing_peripheral_pkg::MODE_CMP_SPECIAL) && adc_enabled_i;
		st_d.tmr_rst = 1'b0;
		if (match_evt && (mode == enhanced_timing_peripheral_pkg::MODE_CMP_SPECIAL)) begin
			st_d.pend_reset = 1'b1;
		end else if (!match_now || mode != enhanced_timing_peripheral_pkg::MODE_CMP_SPECIAL) begin
			st_d.pend_reset = 1'b0;
		end else if (st_q.pend_reset && first_timer_tick_i) begin
			st_d.tmr_rst = 1'b1;
			st_d.pend_reset = 1'b0;
		end
		// Dead band restarts on every edge of the raw PWM level.
		st_d.pwm = pwm_now;
		if (pwm_now != st_q.pwm) begin
			st_d.dead = enhanced_timing_peripheral_pkg::DEAD_CYCLES;
		end else if (st_q.dead != 8'h00) begin
			st_d.dead = st_q.dead - 8'h01;
		end
		// Pin drive per mode family; the output config bit only counts in PWM.
		st_d.p_out = 1'b0;
		st_d.p_oe_n = 1'b1;
		st_d.s_out = 1'b0;
		st_d.s_oe_n = 1'b1;
		if (is_pwm) begin
			st_d.p_oe_n = 1'b0;
			st_d.p_out = (st_q.ctrl[enhanced_timing_peripheral_pkg::CTRL_OUT_CFG_BIT] ? a_act : st_q.pwm)
				^ mode[1];
			if (st_q.ctrl[enhanced_timing_peripheral_pkg::CTRL_OUT_CFG_BIT]) begin
				st_d.s_oe_n = 1'b0;
				st_d.s_out = b_act ^ mode[0];
			end
		end else if (is_compare && mode != enhanced_timing_peripheral_pkg::MODE_CMP_SOFT
			&& mode != enhanced_timing_peripheral_pkg::MODE_CMP_SPECIAL) begin
			// The port direction still decides whether the pin is driven.
			st_d.p_oe_n = pin_direction_bit_i;
			st_d.p_out = st_q.cmp_latch;
		end
		// Off mode holds the compare latch, prescaler, pending reset, dead band and PWM level at reset values.
		if (mode == enhanced_timing_peripheral_pkg::MODE_OFF) begin
			st_d.cmp_latch = 1'b0;
			st_d.presc = 4'h0;
			st_d.pend_reset = 1'b0;
			st_d.dead = 8'h00;
			st_d.pwm = 1'b0;
		end
		if (wr_ctrl && avs_writedata_i[7:0] == enhanced_timing_peripheral_pkg::CONTROL_RESET) begin
			st_d.cmp_latch = 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	// Synchronous active-low reset to constants only.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			st_q <= '0;
			st_q.wait_n <= 1'b1;
			st_q.ctrl <= enhanced_timing_peripheral_pkg::CONTROL_RESET;
			st_q.ccpr <= enhanced_timing_peripheral_pkg::CAPTURE_RESET;
			st_q.p_oe_n <= 1'b1;
			st_q.s_oe_n <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// Every output is a flip-flop of the state.
	assign avs_readdata_o = st_q.rdata;
	assign avs_waitrequest_o = st_q.wait_n;
	assign timer_reset_o = st_q.tmr_rst;
	assign adc_start_o = st_q.adc_go;
	assign peripheral_irq_flag_o = st_q.flag;
	assign primary_output_o = st_q.p_out;
	assign primary_oe_n_o = st_q.p_oe_n;
	assign secondary_output_o = st_q.s_out;
	assign secondary_oe_n_o = st_q.s_oe_n;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	// Off mode keeps the compare latch and prescaler cleared.
	property p_off_reset;
		(mode == enhanced_timing_peripheral_pkg::MODE_OFF) |=> (st_q.cmp_latch == 1'b0) && (st_q.presc == 4'h0);
	endproperty
	a_off_reset: assert property (p_off_reset) else $error("off mode not held in reset");

	// Toggle mode inverts the latch one cycle after a match.
	property p_toggle;
		match_evt && (mode == enhanced_timing_peripheral_pkg::MODE_CMP_TOGGLE) && !wr_ctrl
			|=> (st_q.cmp_latch != $past(st_q.cmp_latch)) && st_q.flag;
	endproperty
	a_toggle: assert property (p_toggle) else $error("toggle compare failed");

	// Set mode drives the pin high two cycles after a match when output.
	property p_set_pin;
		match_evt && (mode == enhanced_timing_peripheral_pkg::MODE_CMP_SET) && !pin_direction_bit_i && !wr_ctrl
			|=> st_q.cmp_latch ##1 (primary_output_o || mode != enhanced_timing_peripheral_pkg::MODE_CMP_SET);
	endproperty
	a_set_pin: assert property (p_set_pin) else $error("set compare failed");

	// Software-interrupt and special modes never drive the primary pin.
	property p_soft_pin;
		(mode == enhanced_timing_peripheral_pkg::MODE_CMP_SOFT || mode == enhanced_timing_peripheral_pkg::MODE_CMP_SPECIAL)
			&& $stable(st_q.ctrl) |=> primary_oe_n_o;
	endproperty
	a_soft_pin: assert property (p_soft_pin) else $error("pin driven in soft mode");

	// Special event: a tick while the reset is pending and the match stands gives a timer reset.
	sequence s_pending;
		st_q.pend_reset && first_timer_tick_i && match_now
			&& (mode == enhanced_timing_peripheral_pkg::MODE_CMP_SPECIAL);
	endsequence
	property p_special;
		s_pending |=> timer_reset_o;
	endproperty
	a_special: assert property (p_special) else $error("timer reset missing");

	// A timer reset pulse never appears outside special event mode.
	property p_reset_only_special;
		timer_reset_o |-> $past(mode) == enhanced_timing_peripheral_pkg::MODE_CMP_SPECIAL;
	endproperty
	a_reset_only_special: assert property (p_reset_only_special) else $error("stray timer reset");

	// A capture event stores the timer and sets the flag.
	property p_capture;
		cap_evt |=> (st_q.ccpr == $past(first_timer_count_i)) && st_q.flag;
	endproperty
	a_capture: assert property (p_capture) else $error("capture value lost");

	// The flag only falls on a software write to the status register.
	property p_flag_clear;
		$fell(st_q.flag) |-> $past(wr_stat) && !$past(avs_writedata_i[0]);
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag cleared by hardware");

	// Outside capture modes the prescaler is zero.
	property p_presc_clear;
		!is_capture |=> st_q.presc == 4'h0 || is_capture;
	endproperty
	a_presc_clear: assert property (p_presc_clear) else $error("prescaler not cleared");

	// Every fourth rise fires and restarts the prescaler.
	property p_presc4;
		(mode == enhanced_timing_peripheral_pkg::MODE_CAP_RISE4) && rise && (st_q.presc == enhanced_timing_peripheral_pkg::PRESC_LAST_4)
			&& !wr_ctrl |=> st_q.presc == 4'h0 && st_q.flag;
	endproperty
	a_presc4: assert property (p_presc4) else $error("prescale by four wrong");

	// Control bit 6 never reads back as one.
	property p_bit6;
		!avs_waitrequest_o && $past(avs_address_i) == enhanced_timing_peripheral_pkg::OFS_CONTROL
			|-> avs_readdata_o[enhanced_timing_peripheral_pkg::CTRL_ZERO_BIT] == 1'b0;
	endproperty
	a_bit6: assert property (p_bit6) else $error("bit 6 read as one");

	// Secondary pin stays a port pin outside PWM modes.
	property p_secondary;
		!is_pwm && $stable(st_q.ctrl) |=> secondary_oe_n_o;
	endproperty
	a_secondary: assert property (p_secondary) else $error("secondary driven outside PWM");
endmodule : enhanced_timing_peripheral_ctrl

// [design/enhanced_timing_peripheral_pkg.sv]
// ---------------------------------------------------------------
// Shared constants of the capture, compare and PWM controller.
// ---------------------------------------------------------------
package enhanced_timing_peripheral_pkg;
	// Register byte offsets on the Avalon-MM slave.
	localparam logic [4:0] OFS_CONTROL = 5'h00; // Mode, duty low bits, output configuration.
	localparam logic [4:0] OFS_CAP_LOW = 5'h04; // Low capture/compare byte.
	localparam logic [4:0] OFS_CAP_HIGH = 5'h08; // High capture/compare byte.
	localparam logic [4:0] OFS_STATUS = 5'h0c; // Peripheral interrupt flag in bit 0.

	// Field positions inside the control register.
	localparam int CTRL_OUT_CFG_BIT = 7; // Output configuration bit.
	localparam int CTRL_ZERO_BIT = 6; // Unimplemented, reads zero.
	localparam int CTRL_DUTY_HI = 5; // Duty low bits, upper position.
	localparam int CTRL_DUTY_LO = 4; // Duty low bits, lower position.
	localparam int CTRL_MODE_HI = 3; // Mode select field, upper position.

	// Reset values.
	localparam logic [7:0] CONTROL_RESET = 8'h00; // Peripheral off.
	localparam logic [15:0] CAPTURE_RESET = 16'h0000; // Capture/compare pair.
	localparam logic [7:0] CONTROL_WMASK = 8'hbf; // Bit 6 is not writable.

	// Mode select codes.
	localparam logic [3:0] MODE_OFF = 4'h0;
	localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;
	localparam logic [3:0] MODE_CAP_FALL = 4'h4;
	localparam logic [3:0] MODE_CAP_RISE = 4'h5;
	localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
	localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
	localparam logic [3:0] MODE_CMP_SET = 4'h8;
	localparam logic [3:0] MODE_CMP_CLEAR = 4'h9;
	localparam logic [3:0] MODE_CMP_SOFT = 4'ha;
	localparam logic [3:0] MODE_CMP_SPECIAL = 4'hb;
	localparam logic [1:0] UPPER_CAPTURE = 2'h1; // Upper mode bits of capture modes.
	localparam logic [1:0] UPPER_PWM = 2'h3; // Upper mode bits of PWM modes.

	// Prescaler terminal counts (edges minus one).
	localparam logic [3:0] PRESC_LAST_4 = 4'h3;
	localparam logic [3:0] PRESC_LAST_16 = 4'hf;

	// Dead band between half-bridge outputs.
	localparam int DEAD_BAND_NS = 200; // Least gap in ns.
	localparam int CLK_PERIOD_NS = 4; // 250 MHz system clock.
	localparam logic [7:0] DEAD_CYCLES = 8'((DEAD_BAND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage : enhanced_timing_peripheral_pkg

// [tb/enhanced_timing_peripheral_ctrl_tb.sv]
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
	$display("BAD %0t got %0h want %0h", $time, (g), (e)); end end
// ---------------------------------------------------------------
// Self-checking bench of the capture, compare and PWM controller.
// ---------------------------------------------------------------
module enhanced_timing_peripheral_ctrl_tb;
	// Design inputs, all given a value at time zero.
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [4:0] avs_address_i = 5'h00;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [3:0] avs_byteenable_i = 4'h0;
	logic [15:0] first_timer_count_i = 16'h0;
	logic first_timer_tick_i = 1'b0;
	logic [9:0] second_timer_count_i = 10'h0;
	logic adc_enabled_i = 1'b0;
	logic pin_direction_bit_i = 1'b1;
	logic port_write_i = 1'b0;
	logic port_data_i = 1'b0;
	// Design outputs, and the capture pin from the pin model.
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o, timer_reset_o, adc_start_o, peripheral_irq_flag_o;
	logic capture_pin_i, primary_output_o, primary_oe_n_o, secondary_output_o, secondary_oe_n_o;
	// Bookkeeping.
	int errors = 0;
	int check_count = 0;
	logic [31:0] rd;
	int adc_seen = 0;
	int trst_seen = 0;
	// Compare modes in a run order chosen so that every step changes the pin.
	logic [7:0] cmp_mode [4] = '{8'h08, 8'h09, 8'h02, 8'h02};
	logic cmp_out [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
	// Prescaled capture modes and their edge counts.
	logic [7:0] pre_mode [2] = '{8'h06, 8'h07};
	int pre_cnt [2] = '{4, 16};

	always #2 clk_i = ~clk_i;

	// One-cycle pulses are counted here, so a test also sees a doubled pulse.
	always @(posedge clk_i) begin
		if (adc_start_o === 1'b1) adc_seen <= adc_seen + 1;
		if (timer_reset_o === 1'b1) trst_seen <= trst_seen + 1;
	end

	enhanced_timing_peripheral_pin_model pin (.clk_i(clk_i), .pin_o(capture_pin_i));

	enhanced_timing_peripheral_ctrl dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .first_timer_count_i(first_timer_count_i),
		.first_timer_tick_i(first_timer_tick_i), .second_timer_count_i(second_timer_count_i),
		.adc_enabled_i(adc_enabled_i), .timer_reset_o(timer_reset_o), .adc_start_o(adc_start_o),
		.peripheral_irq_flag_o(peripheral_irq_flag_o), .capture_pin_i(capture_pin_i),
		.pin_direction_bit_i(pin_direction_bit_i), .port_write_i(port_write_i),
		.port_data_i(port_data_i), .primary_output_o(primary_output_o),
		.primary_oe_n_o(primary_oe_n_o), .secondary_output_o(secondary_output_o),
		.secondary_oe_n_o(secondary_oe_n_o));

	// ---------------------------------------------------------------
	// Tasks.
	// ---------------------------------------------------------------
	// Prints the counts and the verdict, then stops.
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : complete_run

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask : cyc

	// One bus transfer; the value before each edge is what that edge samples.
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] wd,
		input logic [3:0] be, output logic [31:0] d);
		int n;
		logic wait_s;
		n = 0;
		avs_address_i <= a;
		avs_writedata_i <= wd;
		avs_byteenable_i <= be;
		avs_read_i <= !w;
		avs_write_i <= w;
		// The answer and the read data are both taken at the rising edge.
		do begin
			@(posedge clk_i);
			wait_s = avs_waitrequest_o;
			d = avs_readdata_o;
			n++;
		end while (wait_s !== 1'b0 && n < 40);
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		// A slave that never answers ends the run as a failure.
		if (wait_s !== 1'b0) begin
			errors++;
			complete_run();
		end else begin
			// One idle edge, so the next call never reassigns a strobe in this step.
			@(posedge clk_i);
		end
	endtask : bus

	task automatic wr(input logic [4:0] a, input logic [7:0] v);
		bus(1'b1, a, {24'h0, v}, 4'h1, rd);
	endtask : wr

	task automatic ctl(input logic [7:0] v);
		wr(enhanced_timing_peripheral_pkg::OFS_CONTROL, v);
	endtask : ctl

	task automatic rdc(input logic [4:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, 4'hf, rd);
		`CHK(rd, e)
	endtask : rdc

	// Moves the timer onto the pair 0x0110, passing first through a low-byte-only match.
	task automatic hit();
		first_timer_count_i <= 16'h0010;
		cyc(2);
		first_timer_count_i <= 16'h0110;
		cyc(4);
	endtask : hit

	// ---------------------------------------------------------------
	// Main sequence.
	// ---------------------------------------------------------------
	initial begin
		cyc(12);
		rst_n_i <= 1'b1;
		cyc(1);
		// Reset values, unimplemented bit, disabled lane and an unmapped address.
		rdc(enhanced_timing_peripheral_pkg::OFS_CONTROL, 32'h0);
		rdc(enhanced_timing_peripheral_pkg::OFS_STATUS, 32'h0);
		ctl(8'hff);
		rdc(enhanced_timing_peripheral_pkg::OFS_CONTROL, 32'hbf);
		bus(1'b1, enhanced_timing_peripheral_pkg::OFS_CONTROL, 32'h05, 4'h0, rd);
		rdc(enhanced_timing_peripheral_pkg::OFS_CONTROL, 32'hbf);
		bus(1'b1, 5'h10, 32'hff, 4'hf, rd);
		rdc(5'h10, 32'h0);
		$display("test registers done");
		// Rising-edge capture, then a second capture before the flag is cleared.
		ctl(8'h00);
		ctl(8'h05);
		wr(enhanced_timing_peripheral_pkg::OFS_STATUS, 8'h00);
		first_timer_count_i <= 16'h1234;
		pin.pulse(1);
		rdc(enhanced_timing_peripheral_pkg::OFS_CAP_LOW, 32'h34);
		rdc(enhanced_timing_peripheral_pkg::OFS_CAP_HIGH, 32'h12);
		first_timer_count_i <= 16'h5678;
		pin.pulse(1);
		rdc(enhanced_timing_peripheral_pkg::OFS_CAP_HIGH, 32'h56);
		rdc(enhanced_timing_peripheral_pkg::OFS_STATUS, 32'h1);
		wr(enhanced_timing_peripheral_pkg::OFS_STATUS, 8'h00);
		rdc(enhanced_timing_peripheral_pkg::OFS_STATUS, 32'h0);
		// Falling-edge capture ignores the rise.
		ctl(8'h00);
		ctl(8'h04);
		pin.level(1'b1);
		rdc(enhanced_timing_peripheral_pkg::OFS_STATUS, 32'h0);
		pin.level(1'b0);
		rdc(enhanced_timing_peripheral_pkg::OFS_STATUS, 32'h1);
		$display("test capture done");
		// A part-filled prescaler must be cleared by the zero write.
		ctl(8'h06);
		pin.pulse(2);
		for (int i = 0; i < 2; i++) begin
			ctl(8'h00);
			ctl(pre_mode[i]);
			wr(enhanced_timing_peripheral_pkg::OFS_STATUS, 8'h00);
			pin.pulse(pre_cnt[i] - 1);
			rdc(enhanced_timing_peripheral_pkg::OFS_STATUS, 32'h0);
			pin.pulse(1);
			rdc(enhanced_timing_peripheral_pkg::OFS_STATUS, 32'h1);
		end
		$display("test prescaler done");
		// With the pin an output, a port write makes the capture edge.
		ctl(8'h00);
		pin_direction_bit_i <= 1'b0;
		ctl(8'h05);
		wr(enhanced_timing_peripheral_pkg::OFS_STATUS, 8'h00);
		first_timer_count_i <= 16'h0abc;
		port_data_i <= 1'b1;
		port_write_i <= 1'b1;
		cyc(1);
		port_write_i <= 1'b0;
		cyc(4);
		rdc(enhanced_timing_peripheral_pkg::OFS_CAP_LOW, 32'hbc);
		wr(enhanced_timing_peripheral_pkg::OFS_STATUS, 8'h00);
		// Writing the latch back low is a fall, which rising mode ignores.
		port_data_i <= 1'b0;
		port_write_i <= 1'b1;
		cyc(1);
		port_write_i <= 1'b0;
		cyc(4);
		rdc(enhanced_timing_peripheral_pkg::OFS_STATUS, 32'h0);
		$display("test port capture done");
		// Compare set, clear and toggle actions, then the zero write.
		ctl(8'h09);
		wr(enhanced_timing_peripheral_pkg::OFS_CAP_LOW, 8'h10);
		wr(enhanced_timing_peripheral_pkg::OFS_CAP_HIGH, 8'h01);
		wr(enhanced_timing_peripheral_pkg::OFS_STATUS, 8'h00);
		for (int i = 0; i < 4; i++) begin
			ctl(cmp_mode[i]);
			hit();
			`CHK(primary_output_o, cmp_out[i])
			`CHK(primary_oe_n_o, 1'b0)
			rdc(enhanced_timing_peripheral_pkg::OFS_STATUS, 32'h1);
			wr(enhanced_timing_peripheral_pkg::OFS_STATUS, 8'h00);
		end
		// Set the latch, then the zero write must clear it while the timer misses.
		ctl(8'h08);
		hit();
		`CHK(primary_output_o, 1'b1)
		wr(enhanced_timing_peripheral_pkg::OFS_STATUS, 8'h00);
		first_timer_count_i <= 16'h0000;
		ctl(8'h00);
		ctl(8'h09);
		cyc(2);
		`CHK(primary_output_o, 1'b0)
		// Software interrupt mode leaves the pin alone.
		ctl(8'h0a);
		hit();
		`CHK(primary_oe_n_o, 1'b1)
		rdc(enhanced_timing_peripheral_pkg::OFS_STATUS, 32'h1);
		// Special event: trigger at once, timer reset only at the tick.
		// A match with the converter off starts no conversion.
		ctl(8'h0b);
		hit();
		`CHK(adc_seen, 0)
		adc_enabled_i <= 1'b1;
		hit();
		`CHK(adc_seen, 1)
		`CHK(trst_seen, 0)
		first_timer_tick_i <= 1'b1;
		cyc(1);
		first_timer_tick_i <= 1'b0;
		cyc(2);
		`CHK(trst_seen, 1)
		$display("test compare done");
		// The neighbours go back to idle: converter off, pin an input again.
		adc_enabled_i <= 1'b0;
		pin_direction_bit_i <= 1'b1;
		// PWM duty {0x40, 2'b11} is 0x103 against the second timer.
		ctl(8'h3c);
		wr(enhanced_timing_peripheral_pkg::OFS_CAP_LOW, 8'h40);
		second_timer_count_i <= 10'h102;
		cyc(4);
		`CHK(primary_output_o, 1'b1)
		`CHK(secondary_oe_n_o, 1'b1)
		second_timer_count_i <= 10'h103;
		cyc(4);
		`CHK(primary_output_o, 1'b0)
		ctl(8'h3e);
		cyc(4);
		`CHK(primary_output_o, 1'b1)
		// Half-bridge: both pins driven, and the dead band keeps both off after an edge.
		ctl(8'hbc);
		cyc(60);
		`CHK(secondary_oe_n_o, 1'b0)
		`CHK(secondary_output_o, 1'b1)
		second_timer_count_i <= 10'h102;
		cyc(4);
		`CHK(primary_output_o, 1'b0)
		`CHK(secondary_output_o, 1'b0)
		cyc(60);
		`CHK(primary_output_o, 1'b1)
		ctl(8'hbd);
		cyc(4);
		`CHK(secondary_output_o, 1'b1)
		$display("test pwm done");
		// A reset in mid-run returns the registers and the pins to idle.
		rst_n_i <= 1'b0;
		cyc(2);
		rst_n_i <= 1'b1;
		cyc(1);
		`CHK(secondary_oe_n_o, 1'b1)
		rdc(enhanced_timing_peripheral_pkg::OFS_CONTROL, 32'h0);
		rdc(enhanced_timing_peripheral_pkg::OFS_STATUS, 32'h0);
		$display("test reset done");
		complete_run();
	end
endmodule : enhanced_timing_peripheral_ctrl_tb

// [tb/enhanced_timing_peripheral_pin_model.sv]
`timescale 1ns/1ns
// ---------------------------------------------------------------
// External event source on the capture pin.
// ---------------------------------------------------------------
module enhanced_timing_peripheral_pin_model (
	// Clock.
	input wire logic clk_i,
	// Event line.
	output logic pin_o
);
	// The line idles low and is always driven, so it never floats.
	initial pin_o = 1'b0;

	// Sets a level and holds it three cycles, so edges stay far enough apart to be seen.
	task automatic level(input logic v);
		pin_o <= v;
		repeat (3) @(posedge clk_i);
	endtask : level

	// Gives n whole pulses, each one rising edge and one falling edge.
	task automatic pulse(input int n);
		repeat (n) begin
			level(1'b1);
			level(1'b0);
		end
	endtask : pulse
endmodule : enhanced_timing_peripheral_pin_model
